// >>> amcf_defs.vh
// Constants for the converter mode and code-format block
`ifndef AMCF_DEFS_VH
`define AMCF_DEFS_VH
`define AMCF_CODE_W        18
`define AMCF_CODE_MSB      17
`define AMCF_CODE_BIN_TOP  18'h3FFFF
`define AMCF_CODE_BIN_BOT  18'h00000
`define AMCF_CODE_BIN_MID  18'h20000
`define AMCF_CLK_HZ        25000000
`define AMCF_IDLE_LIMIT_US 1000
`define AMCF_IDLE_LIMIT_CYC ((`AMCF_CLK_HZ / 1000000) * `AMCF_IDLE_LIMIT_US)
`define AMCF_RATE_FAST_KSPS 670
`define AMCF_RATE_STD_KSPS  570
`define AMCF_RATE_LOW_KSPS  450
`define AMCF_MODE_FAST     2'h1
`define AMCF_MODE_STD      2'h0
`define AMCF_MODE_LOW      2'h2
`define AMCF_CFG_FAST_BIT  0
`define AMCF_CFG_LOW_BIT   1
`define AMCF_CFG_TWOS_BIT  2
`define AMCF_CFG_BIP_BIT   3
`define AMCF_CFG_DBL_BIT   4
`define AMCF_CFG_W         5
`define AMCF_ADDR_CFG      2'h0
`define AMCF_ADDR_STAT     2'h1
`define AMCF_ADDR_CODE     2'h2
`define AMCF_CFG_RST       5'h00
`endif

// >>> amcf_fmt.v
// Output-code formatter: saturation and binary or twos-complement coding
`include "amcf_defs.vh"
module amcf_fmt (
  input  wire [`AMCF_CODE_MSB:0] raw,
  input  wire                    over,
  input  wire                    under,
  input  wire                    twos,
  output wire [`AMCF_CODE_MSB:0] code
);
  wire [`AMCF_CODE_MSB:0] bin;
  assign bin = over  ? `AMCF_CODE_BIN_TOP :
               under ? `AMCF_CODE_BIN_BOT : raw;
  assign code = twos ? {~bin[`AMCF_CODE_MSB], bin[`AMCF_CODE_MSB-1:0]}
                     : bin;
endmodule // amcf_fmt

// >>> amcf_host.sv
// Host model that strobes conversion start
module amcf_host (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic go,
  input  wire logic busy,
  output logic      convert_start_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // strobe held low until busy seen
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      convert_start_n <= 1'b1;
    else if (go)
      convert_start_n <= 1'b0;
    else if (busy)
      convert_start_n <= 1'b1;
  end
endmodule // amcf_host

// >>> amcf_props.sv
// Assertion checker for the converter mode and code block
module amcf_props #(
  parameter CONV_CYC = 16
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        busy,
  input wire logic [17:0] data_out,
  input wire logic [1:0]  active_mode,
  input wire logic        cal_active,
  input wire logic        power_down
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_cal_fast: assert property (cal_active |-> active_mode == 2'h1)
    else $error("calibration outside fast mode");
  a_pdn_low: assert property (power_down |-> active_mode == 2'h2)
    else $error("power down outside low-power mode");
  // Power down only starts once the conversion is over
  a_pdn_idle: assert property ($rose(power_down) |-> !busy)
    else $error("power down during conversion");
  a_mode_legal: assert property (active_mode != 2'h3)
    else $error("illegal mode code");
  a_busy_min: assert property ($rose(busy) |-> busy [*8])
    else $error("conversion too short");
  a_busy_max: assert property ($rose(busy) |-> ##[8:40] !busy)
    else $error("conversion never ends");
  a_code_hold: assert property (
    !busy && $past(!busy) |-> $stable(data_out))
    else $error("code changed while idle");
  a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  c_fast: cover property (cal_active);
  c_pdn: cover property (power_down);
  c_sat: cover property ($fell(busy) && data_out == 18'h1FFFF);
endmodule // amcf_props

bind amcf_top amcf_props #(.CONV_CYC(CONV_CYC)) u_props (.*);

// >>> amcf_sync.v
// Two-stage synchroniser for a bus of pin levels
module amcf_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         nrst,
  input  wire         ce,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // amcf_sync

// >>> amcf_top.v
// Conversion control, mode selection and code formatting of the converter
// How it works
// - fast pin high, low-power pin low gives fast mode, up to 670 kSPS.
// - fast mode runs background calibration each conversion; 1 ms spacing.
// - equal mode pins give standard mode, 570 kSPS, no spacing limit; cal_stale is still set here when starts are 1 ms or more apart.
// - fast low, low-power high gives low-power mode, 450 kSPS.
// - low-power mode powers internals down after each conversion.
// - binary or twos-complement coding by pin or register; the pin is ignored in 18-bit parallel, the register is not.
// - binary codes 0x3FFFF top, 0x20000 mid, 0x00000 bottom.
// - twos codes 0x1FFFF top, 0x00000 mid, 0x20000 bottom.
// - over-range input saturates at the top code of active coding.
// - under-range input saturates at the bottom code of active coding.
// - range chosen by bipolar pin and double-span pin in pin modes.
// - with register in use, range and coding pins are ignored.
// - with register in use, both mode pins are ignored.
// - host drops convert_start_n to start; busy falls when code ready.
// - new configuration takes effect after one acquisition, no reset.
`include "amcf_defs.vh"
module amcf_top #(
  parameter CONV_CYC   = 16,
  parameter IDLE_LIMIT = `AMCF_IDLE_LIMIT_CYC
) (
  input  wire                    clock,
  input  wire                    nrst,
  input  wire                    ce,
  input  wire                    convert_start_n,
  input  wire                    fast_mode_pin,
  input  wire                    low_power_pin,
  input  wire                    coding_select_pin,
  input  wire                    bipolar_pin,
  input  wire                    double_span_pin,
  input  wire                    parallel18_mode,
  input  wire [`AMCF_CODE_MSB:0] sar_result,
  input  wire                    sar_over,
  input  wire                    sar_under,
  input  wire [1:0]              reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [31:0]             reg_rdata,
  output wire                    busy,
  output reg  [`AMCF_CODE_MSB:0] data_out,
  output reg  [1:0]              active_mode,
  output reg                     active_bipolar,
  output reg                     active_double,
  output reg                     cal_active,
  output reg                     power_down,
  output reg                     cal_stale
);
  localparam S_ACQ  = 3'h1;
  localparam S_CONV = 3'h2;
  localparam S_DONE = 3'h4;
  localparam [31:0] IDLE_LIM32 = IDLE_LIMIT;
  localparam integer CONV_INT  = CONV_CYC;
  localparam [15:0] CONV_LIM   = CONV_INT[15:0];

  wire [5:0] pins_s;
  wire       cnv_n_s;
  wire       fast_s;
  wire       low_s;
  wire       code_s;
  wire       bip_s;
  wire       dbl_s;
  wire       par18_s;
  wire [`AMCF_CODE_MSB:0] fmt_code;

  reg [2:0]              state_r;
  reg [2:0]              state_nxt;
  reg                    cnv_n_d_r;
  reg [15:0]             conv_cnt_r;
  reg [31:0]             idle_cnt_r;
  reg                    use_reg_r;
  reg [`AMCF_CFG_W-1:0]  cfg_r;
  reg                    twos_r;
  reg                    busy_r;

  amcf_sync #(.W(7)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .d     ({convert_start_n, fast_mode_pin, low_power_pin,
             coding_select_pin, bipolar_pin, double_span_pin,
             parallel18_mode}),
    .q     ({cnv_n_s, pins_s})
  );
  assign fast_s  = pins_s[5];
  assign low_s   = pins_s[4];
  assign code_s  = pins_s[3];
  assign bip_s   = pins_s[2];
  assign dbl_s   = pins_s[1];
  assign par18_s = pins_s[0];

  function [1:0] mode_dec;
    input f;
    input l;
    begin
      if (f && !l)
        mode_dec = `AMCF_MODE_FAST;
      else if (!f && l)
        mode_dec = `AMCF_MODE_LOW;
      else
        mode_dec = `AMCF_MODE_STD;
    end
  endfunction

  wire start_ev = cnv_n_d_r & ~cnv_n_s;
  // Mode that the next acquisition latches
  wire [1:0] mode_src = use_reg_r ?
                        mode_dec(cfg_r[`AMCF_CFG_FAST_BIT],
                                 cfg_r[`AMCF_CFG_LOW_BIT]) :
                        mode_dec(fast_s, low_s);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_ACQ: begin
        if (start_ev)
          state_nxt = S_CONV;
      end
      S_CONV: begin
        if (conv_cnt_r == CONV_LIM - 16'h0001)
          state_nxt = S_DONE;
      end
      S_DONE: begin
        state_nxt = S_ACQ;
      end
      default: begin
        state_nxt = S_ACQ;
      end
    endcase
  end

  // Register port: config, status and last code
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_r     <= `AMCF_CFG_RST;
      use_reg_r <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (reg_wr && reg_addr == `AMCF_ADDR_CFG) begin
        cfg_r     <= reg_wdata[`AMCF_CFG_W-1:0];
        use_reg_r <= reg_wdata[31];
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `AMCF_ADDR_CFG:
            reg_rdata <= {use_reg_r, 26'h0000000, cfg_r};
          `AMCF_ADDR_STAT:
            reg_rdata <= {24'h000000, cal_stale, power_down, cal_active,
                          busy_r, active_mode, active_double,
                          active_bipolar};
          `AMCF_ADDR_CODE:
            reg_rdata <= {14'h0000, data_out};
          default:
            reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r        <= S_ACQ;
      // Sync stages reset low too, so no false start edge
      cnv_n_d_r      <= 1'b0;
      conv_cnt_r     <= 16'h0000;
      idle_cnt_r     <= 32'h00000000;
      busy_r         <= 1'b0;
      data_out       <= 18'h00000;
      active_mode    <= `AMCF_MODE_STD;
      active_bipolar <= 1'b0;
      active_double  <= 1'b0;
      twos_r         <= 1'b0;
      cal_active     <= 1'b0;
      power_down     <= 1'b0;
      cal_stale      <= 1'b1;
    end else if (ce) begin
      state_r   <= state_nxt;
      cnv_n_d_r <= cnv_n_s;
      if (idle_cnt_r != IDLE_LIM32)
        idle_cnt_r <= idle_cnt_r + 32'h00000001;
      if (state_r == S_ACQ) begin
        if (use_reg_r) begin
          active_mode    <= mode_dec(cfg_r[`AMCF_CFG_FAST_BIT],
                                     cfg_r[`AMCF_CFG_LOW_BIT]);
          twos_r         <= cfg_r[`AMCF_CFG_TWOS_BIT];
          active_bipolar <= cfg_r[`AMCF_CFG_BIP_BIT];
          active_double  <= cfg_r[`AMCF_CFG_DBL_BIT];
        end else begin
          active_mode    <= mode_dec(fast_s, low_s);
          // no coding choice in 18-bit parallel
          twos_r         <= code_s & ~par18_s;
          active_bipolar <= bip_s;
          active_double  <= dbl_s;
        end
        // leaving low-power mode wakes the circuits
        if (mode_src != `AMCF_MODE_LOW)
          power_down <= 1'b0;
      end
      if (start_ev && state_r == S_ACQ) begin
        busy_r     <= 1'b1;
        conv_cnt_r <= 16'h0000;
        power_down <= 1'b0;
        cal_active <= (mode_src == `AMCF_MODE_FAST);
        cal_stale  <= (idle_cnt_r == IDLE_LIM32);
        idle_cnt_r <= 32'h00000000;
      end
      if (state_r == S_CONV)
        conv_cnt_r <= conv_cnt_r + 16'h0001;
      if (state_r == S_DONE) begin
        data_out   <= fmt_code;
        busy_r     <= 1'b0;
        cal_active <= 1'b0;
        power_down <= (active_mode == `AMCF_MODE_LOW);
      end
    end
  end

  assign busy = busy_r;

  amcf_fmt u_fmt (
    .raw   (sar_result),
    .over  (sar_over),
    .under (sar_under),
    .twos  (twos_r),
    .code  (fmt_code)
  );
endmodule // amcf_top

// >>> tb_top.sv
// Self-checking bench for the converter mode and code block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, go = 0, rwr = 0, rrd = 0;
  logic fm = 0, lp = 0, cs = 0, bp = 0, ds = 0, p18 = 0, ov = 0, un = 0;
  logic cv_n, busy, ab, ad, ca, pd, st, cav, en = 1;
  logic [17:0] raw = 18'h00000, dout;
  logic [1:0]  ra = 2'h0, am;
  logic [31:0] wd = 32'h0, rdat, rv;
  int n_mismatch = 0, cmp_count = 0, wk, i;
  // Row: pins {par,fast,low,twos,over,under}, raw, mode, code
  logic [43:0] rows [10] = '{
    {6'h10, 18'h3FFFF, 2'h1, 18'h3FFFF}, {6'h04, 18'h20000, 2'h0, 18'h00000},
    {6'h1C, 18'h00000, 2'h0, 18'h20000}, {6'h08, 18'h20000, 2'h2, 18'h20000},
    {6'h02, 18'h12345, 2'h0, 18'h3FFFF}, {6'h06, 18'h12345, 2'h0, 18'h1FFFF},
    {6'h05, 18'h12345, 2'h0, 18'h20000}, {6'h01, 18'h12345, 2'h0, 18'h00000},
    {6'h04, 18'h2A5C3, 2'h0, 18'h0A5C3}, {6'h24, 18'h2A5C3, 2'h0, 18'h2A5C3}};
  always #20 clock = ~clock;
  amcf_top #(.CONV_CYC(16), .IDLE_LIMIT(50)) u_dut (
    .clock(clock), .nrst(nrst), .ce(en), .convert_start_n(cv_n),
    .fast_mode_pin(fm), .low_power_pin(lp), .coding_select_pin(cs),
    .bipolar_pin(bp), .double_span_pin(ds), .parallel18_mode(p18),
    .sar_result(raw), .sar_over(ov), .sar_under(un), .reg_addr(ra),
    .reg_wdata(wd), .reg_wr(rwr), .reg_rd(rrd), .reg_rdata(rdat),
    .busy(busy), .data_out(dout), .active_mode(am), .active_bipolar(ab),
    .active_double(ad), .cal_active(ca), .power_down(pd), .cal_stale(st));
  amcf_host u_host (.clock(clock), .nrst(nrst), .go(go), .busy(busy),
    .convert_start_n(cv_n));
  task chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick;
    @(posedge clock);
    #1 wk++;
  endtask
  // Pins pass two sync stages, so settle before the strobe
  task conv;
    repeat (4) @(posedge clock);
    go <= 1'b1;
    @(posedge clock) go <= 1'b0;
    wk = 0;
    do tick(); while (!busy && wk < 20);
    chk("conv_busy", busy, 1'b1);
    cav = ca;
    do tick(); while (busy && wk < 200);
    chk("conv_done", {31'h0, wk < 200}, 32'h1);
  endtask
  task wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clock);
    ra <= a;
    wd <= d;
    rwr <= 1'b1;
    @(posedge clock) rwr <= 1'b0;
  endtask
  task rd(input logic [1:0] a);
    @(posedge clock);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clock) rrd <= 1'b0;
    #1 rv = rdat;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    tick();
    chk("rst_mode", am, 2'h0);
    chk("rst_stale", st, 1'b1);
    for (i = 0; i < 10; i++) begin
      @(posedge clock);
      {p18, fm, lp, cs, ov, un, raw} <= rows[i][43:20];
      conv();
      chk("mode", am, rows[i][19:18]);
      chk("code", dout, rows[i][17:0]);
      chk("cal", cav, rows[i][19:18] == 2'h1);
      chk("pdn", pd, rows[i][19:18] == 2'h2);
    end
    {p18, fm, lp, cs, bp, ds} <= 6'h13;
    conv();
    conv();
    chk("stale_short", st, 1'b0);
    chk("range", {ab, ad}, 2'h3);
    repeat (80) @(posedge clock);
    conv();
    // The host would drop this result
    chk("stale_long", st, 1'b1);
    // mode pins set to low-power while the register selects fast
    {fm, lp} <= 2'h1;
    wr(2'h0, 32'h80000005);
    conv();
    chk("reg_mode", am, 2'h1);
    chk("reg_code", dout, 18'h0A5C3);
    chk("reg_range", {ab, ad}, 2'h0);
    rd(2'h1);
    chk("stat_mode", rv[3:2], 2'h1);
    rd(2'h3);
    chk("unmapped", rv, 32'h0);
    // Clock enable low: the write must be lost
    en <= 1'b0;
    wr(2'h0, 32'h0);
    en <= 1'b1;
    rd(2'h0);
    chk("ce_hold", rv, 32'h80000005);
    // Reset in mid-run, held over two edges
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    tick();
    chk("rst2_mode", am, 2'h0);
    chk("rst2_stale", st, 1'b1);
    chk("rst2_code", dout, 18'h00000);
    chk("rst2_busy", busy, 1'b0);
    chk("rst2_pdn", pd, 1'b0);
    rd(2'h0);
    chk("rst2_cfg", rv, 32'h0);
    results();
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    results();
  end
endmodule // tb_top
